// ===== ssmc_pkg.sv
// Shared constants, types and helpers for the SPI slave and mode control block
package ssmc_pkg;

  localparam int FRAME_BITS = 16;
  localparam int ADDR_W = 5;
  localparam int ADDR_LSB = 10;
  localparam int DATA_W = 10;
  localparam int WDOG_BIT = 15;
  localparam int REG_COUNT = 32;
  localparam int EDGE_CNT_W = 8;
  localparam logic [EDGE_CNT_W-1:0] FRAME_EDGES = 8'h10;

  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_ON = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h01;
  localparam int CFG_SUPPLY_LOSS_EN_BIT = 0;
  localparam int CFG_OV_GATE_BIT = 1;
  localparam logic [DATA_W-1:0] OUTPUT_ON_RESET = 10'h000;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 10'h002;
  localparam logic [DATA_W-1:0] OTHER_RESET = 10'h000;
  localparam logic [FRAME_BITS-1:0] STATUS_RESET = 16'h0000;

  localparam int SYNC_STAGES = 3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDOG_TIMEOUT_US = 10000;
  localparam int WDOG_TIMEOUT_CYC_DEF = (WDOG_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int RETRY_TIME_US = 1000;
  localparam int RETRY_CYC_DEF = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SSMC_SLEEP,
    SSMC_NORMAL,
    SSMC_FAILSAFE,
    SSMC_FAULT
  } ssmc_mode_t;

  typedef struct packed {
    logic [3:0] overcurrent_flag;
    logic [3:0] overtemperature_flag;
    logic [3:0] severe_short_flag;
    logic undervoltage_flag;
    logic overvoltage_flag;
  } ssmc_fault_t;

  typedef struct packed {
    logic cs_n;
    logic wake;
    logic strap_open;
    logic supply_fail;
    logic [3:0] direct;
    ssmc_fault_t fault;
  } ssmc_pins_t;

  localparam ssmc_pins_t PINS_RESET = ssmc_pins_t'(22'h200000);

  typedef struct packed {
    logic normal;
    ssmc_mode_t mode;
    logic [3:0] outputs;
    logic [3:0] chan_fault;
    logic undervoltage;
    logic overvoltage;
    logic fail;
    logic wdog_timeout;
    logic strap_open;
  } ssmc_status_t;

  function automatic logic [EDGE_CNT_W-1:0] ssmc_gray2bin(input logic [EDGE_CNT_W-1:0] g);
    logic [EDGE_CNT_W-1:0] b;
    b = '0;
    b[EDGE_CNT_W-1] = g[EDGE_CNT_W-1];
    // Top bit seeded first so no index past the vector is ever read
    for (int i = EDGE_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : ssmc_gray2bin

endpackage : ssmc_pkg

// ===== ssmc_spi_master_model.sv
// Behavioural SPI master model that sends command frames of a given bit count, up to sixteen
`timescale 1ns/1ns
module ssmc_spi_master_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // Clock stands low between frames; chip select only moves while it is low
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx, output logic oe_mid);
    rx = 16'h0000;
    oe_mid = 1'b0;
    #100 cs_n_out = 1'b0;
    #600;
    oe_mid = so_oe_in;
    for (int i = 0; i < nbits; i++) begin
      sclk_out = 1'b1;
      si_out = tx[15 - i];
      #32 rx[15 - i] = so_in;
      sclk_out = 1'b0;
      #32;
    end
    #300 cs_n_out = 1'b1;
    // Released input falls to its pull-down level
    si_out = 1'b0;
    #1200;
  endtask : xfer
endmodule : ssmc_spi_master_model

// ===== ssmc_spi_mode_ctrl.sv
// SPI slave port and operating mode control for a quad high-side switch
`timescale 1ns/1ns
module ssmc_spi_mode_ctrl #(
  parameter int WDOG_TIMEOUT_CYCLES = ssmc_pkg::WDOG_TIMEOUT_CYC_DEF,
  parameter int RETRY_CYCLES = ssmc_pkg::RETRY_CYC_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_si_in,
  output logic spi_so_out,
  output logic spi_so_oe_out,
  input wire logic wake_in,
  input wire logic [3:0] direct_in,
  input wire logic watchdog_strap_input_in,
  input wire logic supply_fail_in,
  input wire ssmc_pkg::ssmc_fault_t fault_flags_in,
  output logic [3:0] switch_output_out,
  output ssmc_pkg::ssmc_mode_t mode_out
);
  import ssmc_pkg::*;

  // ---------------- Link side, serial clock domain ----------------
  logic [FRAME_BITS-1:0] rx_shift_reg;
  logic [EDGE_CNT_W-1:0] fall_cnt_reg;
  logic [EDGE_CNT_W-1:0] fall_gray_reg;
  logic [EDGE_CNT_W-1:0] fall_cnt_next;
  logic [FRAME_BITS-1:0] tx_shift_reg;
  logic tx_loaded_reg;
  logic so_reg;
  logic [FRAME_BITS-1:0] status_hold_reg;

  assign fall_cnt_next = fall_cnt_reg + 8'h01;

  // Edge count leaves this domain gray coded, so a late sample is off by one at worst
  always_ff @(negedge spi_sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_shift_reg <= '0;
      fall_cnt_reg <= '0;
      fall_gray_reg <= '0;
    end else if (!spi_cs_n_in) begin
      rx_shift_reg <= {rx_shift_reg[FRAME_BITS-2:0], spi_si_in};
      fall_cnt_reg <= fall_cnt_next;
      fall_gray_reg <= fall_cnt_next ^ (fall_cnt_next >> 1);
    end
  end

  // Status word is held steady by the core from chip select fall until the next fall,
  // and the master's lead time covers the core's capture latency
  always_ff @(posedge spi_sclk_in or negedge rstn_in or posedge spi_cs_n_in) begin
    if (!rstn_in) begin
      tx_shift_reg <= '0;
      tx_loaded_reg <= 1'b0;
      so_reg <= 1'b0;
    end else if (spi_cs_n_in) begin
      tx_shift_reg <= '0;
      tx_loaded_reg <= 1'b0;
      so_reg <= 1'b0;
    end else if (!tx_loaded_reg) begin
      so_reg <= status_hold_reg[FRAME_BITS-1];
      tx_shift_reg <= {status_hold_reg[FRAME_BITS-2:0], 1'b0};
      tx_loaded_reg <= 1'b1;
    end else begin
      so_reg <= tx_shift_reg[FRAME_BITS-1];
      tx_shift_reg <= {tx_shift_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign spi_so_out = so_reg;

  // ---------------- Core side, internal clock domain ----------------
  ssmc_pins_t pins_raw;
  ssmc_pins_t sync1_reg;
  ssmc_pins_t sync2_reg;
  ssmc_pins_t sync3_reg;
  ssmc_pins_t pin_q_reg;

  assign pins_raw = '{cs_n: spi_cs_n_in, wake: wake_in, strap_open: watchdog_strap_input_in,
                      supply_fail: supply_fail_in, direct: direct_in, fault: fault_flags_in};

  // A bit changes only once the second and third stages agree
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= PINS_RESET;
      sync2_reg <= PINS_RESET;
      sync3_reg <= PINS_RESET;
      pin_q_reg <= PINS_RESET;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_q_reg <= (sync2_reg & sync3_reg) | (pin_q_reg & (sync2_reg | sync3_reg));
    end
  end

  logic [EDGE_CNT_W-1:0] gray1_reg;
  logic [EDGE_CNT_W-1:0] gray2_reg;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gray1_reg <= '0;
      gray2_reg <= '0;
    end else begin
      gray1_reg <= fall_gray_reg;
      gray2_reg <= gray1_reg;
    end
  end

  logic cs_q;
  logic cs_prev_reg;
  logic cs_fall;
  logic cs_rise;
  logic [EDGE_CNT_W-1:0] start_cnt_reg;
  logic [EDGE_CNT_W-1:0] frame_edges;
  logic frame_ok;
  logic [ADDR_W-1:0] rx_addr;
  logic [DATA_W-1:0] rx_data;
  logic rx_wdog_bit;

  assign cs_q = pin_q_reg.cs_n;
  assign cs_fall = cs_prev_reg && !cs_q;
  assign cs_rise = !cs_prev_reg && cs_q;
  assign frame_edges = ssmc_gray2bin(gray2_reg) - start_cnt_reg;
  assign frame_ok = (frame_edges == FRAME_EDGES);
  // Receive word is still while chip select is high; sampled only on its rise
  assign rx_addr = rx_shift_reg[ADDR_LSB +: ADDR_W];
  assign rx_data = rx_shift_reg[DATA_W-1:0];
  assign rx_wdog_bit = rx_shift_reg[WDOG_BIT];

  // Serial clock is low at chip select edges, so the edge count is settled here
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_prev_reg <= 1'b1;
      start_cnt_reg <= '0;
    end else begin
      cs_prev_reg <= cs_q;
      if (cs_fall) begin
        start_cnt_reg <= ssmc_gray2bin(gray2_reg);
      end
    end
  end

  logic [DATA_W-1:0] reg_mem [REG_COUNT];
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        reg_mem[i] <= OTHER_RESET;
      end
      reg_mem[ADDR_OUTPUT_ON] <= OUTPUT_ON_RESET;
      reg_mem[ADDR_CONFIG] <= CONFIG_RESET;
    end else if (cs_rise && frame_ok) begin
      reg_mem[rx_addr] <= rx_data;
    end
  end

  ssmc_mode_t mode_reg;
  logic [3:0] on_eff;
  logic [DATA_W-1:0] cfg_eff;

  // Sleep masks every configured feature regardless of stored contents
  assign on_eff = (mode_reg == SSMC_SLEEP) ? 4'h0 : reg_mem[ADDR_OUTPUT_ON][3:0];
  assign cfg_eff = (mode_reg == SSMC_SLEEP) ? 10'h000 : reg_mem[ADDR_CONFIG];

  // Watchdog
  logic wdog_prev_bit_reg;
  logic [31:0] wdog_cnt_reg;
  logic wdog_timeout_reg;
  logic wdog_run;
  logic wdog_kick;
  logic frame_done;

  assign frame_done = cs_rise && frame_ok;
  assign wdog_run = pin_q_reg.strap_open && (mode_reg == SSMC_NORMAL);
  assign wdog_kick = frame_done && (rx_wdog_bit != wdog_prev_bit_reg);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdog_prev_bit_reg <= 1'b0;
    end else if (frame_done) begin
      wdog_prev_bit_reg <= rx_wdog_bit;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdog_cnt_reg <= '0;
    end else if (!wdog_run || wdog_kick) begin
      wdog_cnt_reg <= '0;
    end else if (wdog_cnt_reg != 32'(WDOG_TIMEOUT_CYCLES - 1)) begin
      wdog_cnt_reg <= wdog_cnt_reg + 32'h00000001;
    end
  end

  // Timeout sticks until bit 15 arrives set or the strap is grounded; expiry wins
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdog_timeout_reg <= 1'b0;
    end else if (wdog_run && !wdog_kick && wdog_cnt_reg == 32'(WDOG_TIMEOUT_CYCLES - 1)) begin
      wdog_timeout_reg <= 1'b1;
    end else if (!pin_q_reg.strap_open || (frame_done && rx_wdog_bit)) begin
      wdog_timeout_reg <= 1'b0;
    end
  end

  // Mode terms
  logic rst_done_reg;
  logic wake_reg;
  logic fail_reg;
  logic fault_reg;
  logic [3:0] chan_fault;

  assign chan_fault = pin_q_reg.fault.overcurrent_flag | pin_q_reg.fault.overtemperature_flag |
                      pin_q_reg.fault.severe_short_flag;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_done_reg <= 1'b0;
      wake_reg <= 1'b0;
      fail_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      rst_done_reg <= 1'b1;
      wake_reg <= rst_done_reg || pin_q_reg.wake || (|pin_q_reg.direct);
      fail_reg <= (pin_q_reg.supply_fail && cfg_eff[CFG_SUPPLY_LOSS_EN_BIT]) ||
                  (wdog_timeout_reg && pin_q_reg.strap_open);
      fault_reg <= (|chan_fault) || pin_q_reg.fault.undervoltage_flag ||
                   (pin_q_reg.fault.overvoltage_flag && cfg_eff[CFG_OV_GATE_BIT]);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_reg <= SSMC_SLEEP;
    end else if (!wake_reg) begin
      mode_reg <= SSMC_SLEEP;
    end else if (fault_reg) begin
      mode_reg <= SSMC_FAULT;
    end else if (fail_reg) begin
      mode_reg <= SSMC_FAILSAFE;
    end else begin
      mode_reg <= SSMC_NORMAL;
    end
  end

  // Faulted channels stay off in fault mode until the retry period lapses; a live fault relatches
  logic [3:0] chan_latch_reg;
  logic [31:0] retry_cnt_reg;
  logic retry_now;

  assign retry_now = (retry_cnt_reg == 32'(RETRY_CYCLES - 1));

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      retry_cnt_reg <= '0;
    end else if (chan_latch_reg == 4'h0 || retry_now) begin
      retry_cnt_reg <= '0;
    end else begin
      retry_cnt_reg <= retry_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chan_latch_reg <= 4'h0;
    end else begin
      chan_latch_reg <= chan_fault | (retry_now ? 4'h0 : chan_latch_reg);
    end
  end

  logic [3:0] switch_reg;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      switch_reg <= 4'h0;
    end else begin
      unique case (mode_reg)
        SSMC_SLEEP: switch_reg <= 4'h0;
        SSMC_NORMAL: switch_reg <= on_eff;
        SSMC_FAILSAFE: switch_reg <= pin_q_reg.direct;
        SSMC_FAULT: switch_reg <= (fail_reg ? pin_q_reg.direct : on_eff) & ~chan_latch_reg;
      endcase
    end
  end

  ssmc_status_t status_word;
  assign status_word = '{normal: (mode_reg == SSMC_NORMAL), mode: mode_reg, outputs: switch_reg,
                         chan_fault: chan_latch_reg, undervoltage: pin_q_reg.fault.undervoltage_flag,
                         overvoltage: pin_q_reg.fault.overvoltage_flag, fail: fail_reg,
                         wdog_timeout: wdog_timeout_reg, strap_open: pin_q_reg.strap_open};

  logic so_oe_reg;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_hold_reg <= STATUS_RESET;
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= !cs_q;
      if (cs_fall) begin
        status_hold_reg <= status_word;
      end
    end
  end

  assign spi_so_oe_out = so_oe_reg;
  assign switch_output_out = switch_reg;
  assign mode_out = mode_reg;

  // ---------------- Checks ----------------
  default clocking core_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  chk_sleep_no_wake: assert property (!wake_reg |=> mode_reg == SSMC_SLEEP)
    else $error("no wake-up but not sleeping");
  chk_sleep_outputs_off: assert property (mode_reg == SSMC_SLEEP |=> switch_output_out == 4'h0)
    else $error("outputs on in sleep");
  chk_fault_wins: assert property (wake_reg && fault_reg |=> mode_reg == SSMC_FAULT)
    else $error("fault did not select fault mode");
  chk_failsafe_mode_sel: assert property (wake_reg && fail_reg && !fault_reg |=> mode_reg == SSMC_FAILSAFE)
    else $error("fail did not select fail-safe");
  chk_failsafe_direct: assert property (mode_reg == SSMC_FAILSAFE |=>
                                        switch_output_out == $past(pin_q_reg.direct))
    else $error("fail-safe outputs not from direct inputs");
  chk_normal_spi_on: assert property (mode_reg == SSMC_NORMAL |=> switch_output_out == $past(on_eff))
    else $error("normal outputs not from serial command");
  chk_oe_cs_high: assert property (cs_q |=> !spi_so_oe_out)
    else $error("serial output enabled with chip select high");
  chk_write_on_rise: assert property (cs_rise && frame_ok |=> reg_mem[$past(rx_addr)] == $past(rx_data))
    else $error("valid frame not written");
  chk_bad_frame_drop: assert property (cs_rise && !frame_ok |=>
                                       $stable(reg_mem[ADDR_OUTPUT_ON]) && $stable(reg_mem[ADDR_CONFIG]))
    else $error("short or long frame wrote a register");
  chk_status_capture: assert property (cs_fall |=> status_hold_reg == $past(status_word))
    else $error("status not loaded at chip select fall");
  chk_supply_fail_term: assert property (pin_q_reg.supply_fail && cfg_eff[CFG_SUPPLY_LOSS_EN_BIT] |=> fail_reg)
    else $error("enabled supply failure did not raise fail");
  chk_ov_gate_off: assert property (pin_q_reg.fault == ssmc_fault_t'(14'h0001) && !cfg_eff[CFG_OV_GATE_BIT]
                                    |=> !fault_reg)
    else $error("ungated overvoltage raised fault");

  cov_normal_mode: cover property (mode_reg == SSMC_NORMAL ##1 switch_output_out != 4'h0);
  cov_failsafe_mode: cover property (mode_reg == SSMC_NORMAL ##[1:1000] mode_reg == SSMC_FAILSAFE);
  cov_fault_mode: cover property (mode_reg == SSMC_FAULT);
  cov_valid_write: cover property (cs_rise && frame_ok);

endmodule : ssmc_spi_mode_ctrl

// ===== tb_top.sv
// Self-checking bench for the SPI slave and mode control block
`timescale 1ns/1ns
module tb_top;
  import ssmc_pkg::*;
  localparam int WDOG_CYC = 2000;
  localparam int RETRY_CYC = 50;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sclk, cs_n, si, so, so_oe;
  logic wake = 1'b0;
  logic strap = 1'b0;
  logic supply_fail = 1'b0;
  logic [3:0] direct = 4'h0;
  logic [3:0] sw;
  ssmc_fault_t flags = '0;
  ssmc_mode_t mode;
  logic [15:0] rx;
  logic oe_mid;
  int fails = 0;
  int checked = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  ssmc_spi_mode_ctrl #(.WDOG_TIMEOUT_CYCLES(WDOG_CYC), .RETRY_CYCLES(RETRY_CYC)) ssmc_spi_mode_ctrl_inst (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n),
    .spi_si_in(si),
    .spi_so_out(so),
    .spi_so_oe_out(so_oe),
    .wake_in(wake),
    .direct_in(direct),
    .watchdog_strap_input_in(strap),
    .supply_fail_in(supply_fail),
    .fault_flags_in(flags),
    .switch_output_out(sw),
    .mode_out(mode)
  );

  ssmc_spi_master_model ssmc_spi_master_model_inst (
    .sclk_out(sclk),
    .cs_n_out(cs_n),
    .si_out(si),
    .so_in(so),
    .so_oe_in(so_oe)
  );

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic expect_mode(input ssmc_mode_t m, input logic [3:0] s);
    check({14'h0000, mode}, {14'h0000, m});
    check({12'h000, sw}, {12'h000, s});
  endtask : expect_mode

  // Realigns to the core clock so later pin changes keep the same offset
  task automatic send(input logic [15:0] word, input int nbits);
    ssmc_spi_master_model_inst.xfer(word, nbits, rx, oe_mid);
    step(20);
  endtask : send

  task automatic t_reset;
    step(4);
    expect_mode(SSMC_SLEEP, 4'h0);
    check({15'h0000, so_oe}, 16'h0000);
    rstn_in = 1'b1;
    step(20);
    expect_mode(SSMC_NORMAL, 4'h0);
  endtask : t_reset

  task automatic t_frames;
    send(16'h000F, 16);
    check(rx, 16'hA000);
    check({15'h0000, oe_mid}, 16'h0001);
    check({14'h0000, so_oe, so}, 16'h0000);
    expect_mode(SSMC_NORMAL, 4'hF);
    // Storage-only address must leave the output register alone
    send(16'h0800, 16);
    check(rx, 16'hBE00);
    expect_mode(SSMC_NORMAL, 4'hF);
  endtask : t_frames

  task automatic t_short;
    send(16'h0003, 15);
    expect_mode(SSMC_NORMAL, 4'hF);
    send(16'h0003, 16);
    expect_mode(SSMC_NORMAL, 4'h3);
    send(16'h000F, 16);
  endtask : t_short

  task automatic t_fault;
    flags.overcurrent_flag = 4'h2;
    step(20);
    expect_mode(SSMC_FAULT, 4'hD);
    flags = '0;
    step(200);
    expect_mode(SSMC_NORMAL, 4'hF);
    flags.overvoltage_flag = 1'b1;
    step(20);
    expect_mode(SSMC_FAULT, 4'hF);
    send(16'h0400, 16);
    expect_mode(SSMC_NORMAL, 4'hF);
    flags.overvoltage_flag = 1'b0;
    flags.undervoltage_flag = 1'b1;
    step(20);
    expect_mode(SSMC_FAULT, 4'hF);
    flags = '0;
    step(20);
  endtask : t_fault

  task automatic t_reset_mid;
    rstn_in = 1'b0;
    step(4);
    expect_mode(SSMC_SLEEP, 4'h0);
    rstn_in = 1'b1;
    step(20);
    expect_mode(SSMC_NORMAL, 4'h0);
  endtask : t_reset_mid

  task automatic t_supply;
    direct = 4'h6;
    supply_fail = 1'b1;
    step(20);
    expect_mode(SSMC_NORMAL, 4'h0);
    send(16'h0401, 16);
    expect_mode(SSMC_FAILSAFE, 4'h6);
    // Fault on top of fail: direct drive with the faulted channel held off
    flags.overcurrent_flag = 4'h2;
    step(20);
    expect_mode(SSMC_FAULT, 4'h4);
    // Live fault must relatch across two retry periods
    step(100);
    expect_mode(SSMC_FAULT, 4'h4);
    flags = '0;
    step(20);
    expect_mode(SSMC_FAILSAFE, 4'h6);
    supply_fail = 1'b0;
    step(20);
    expect_mode(SSMC_NORMAL, 4'h0);
  endtask : t_supply

  task automatic t_watchdog;
    strap = 1'b1;
    step(WDOG_CYC + 200);
    expect_mode(SSMC_FAILSAFE, 4'h6);
    send(16'h8000, 16);
    expect_mode(SSMC_NORMAL, 4'h0);
    // Toggled bit 15 inside the period restarts the count; without it this would expire
    step(1500);
    send(16'h0000, 16);
    step(1500);
    expect_mode(SSMC_NORMAL, 4'h0);
    strap = 1'b0;
  endtask : t_watchdog

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Tests need about 150 us; a hang stops here
  initial begin
    #300000;
    fails++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    test_done();
  end

  initial begin
    t_reset();
    t_frames();
    t_short();
    t_fault();
    t_reset_mid();
    t_supply();
    t_watchdog();
    test_done();
  end
endmodule : tb_top
